// ---- design/pgm_hyst_detect.v ----
// One-sided position comparator with hysteresis
`timescale 1ns/1ps
module pgm_hyst_detect (
	input  wire               core_clk_i,
	input  wire               sys_rst_i,
	input  wire               enable_i,
	input  wire signed [32:0] pos_i,
	input  wire signed [32:0] level_i,
	input  wire signed [32:0] hyst_i,
	output reg                flag_o
);

	// ----------------------------------------
	// Set above level, release at or below level minus width
	// ----------------------------------------
	// Hysteresis keeps a position jittering at the level from chattering
	always @(posedge core_clk_i) begin
		if (sys_rst_i || !enable_i) begin
			flag_o <= 1'b0;
		end else if (!flag_o && (pos_i > level_i)) begin
			flag_o <= 1'b1;
		end else if (flag_o && (pos_i <= level_i - hyst_i)) begin
			flag_o <= 1'b0;
		end
	end

endmodule

// ---- design/pgm_position_gear.v ----
// Electronic gear, position status flags, terminal routing and APB registers
//
// Operation
// - Gear numerator and denominator, 1 to 32767
// - Ratio clamped between 1/900 and 900
// - Geared position counts 5120 pulses per rev
// - In-position when geared droop below width
// - Busy flag follows command generation
// - Complete is in-position and not busy
// - Rough match when remaining distance below range
// - Detected when position exceeds detection value
// - Detection value from two four-digit fields
// - Side select: both, plus, minus
// - Hysteresis width stops detect flag chatter
// - Three terminals, code plus hundred inverts
`timescale 1ns/1ps
`include "pgm_regs.vh"
module pgm_position_gear (
	input  wire        core_clk_i,
	input  wire        sys_rst_i,
	input  wire [7:0]  paddr_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	input  wire        cmd_pulse_i,
	input  wire        cmd_dir_i,
	output reg         cmd_ready_o,
	input  wire        cmd_creating_i,
	input  wire [31:0] fb_pos_i,
	input  wire [31:0] target_pos_i,
	input  wire [31:0] cur_pos_i,
	output reg  [2:0]  term_o,
	output reg         irq_o
);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	reg [14:0]            gear_numerator;
	reg [14:0]            gear_denominator;
	reg [14:0]            in_position_width;
	reg [14:0]            detect_hysteresis_width;
	reg [14:0]            rough_match_range;
	reg [13:0]            detect_value_low_digits;
	reg [13:0]            detect_value_high_digits;
	reg [1:0]             detect_side_select;
	reg [23:0]            term_sel;
	reg [`PGM_NFLAGS-1:0] irq_stat;
	reg [`PGM_NFLAGS-1:0] irq_en;

	// ----------------------------------------
	// Gear state and flags
	// ----------------------------------------
	reg  [15:0]            gear_rem;
	reg                    gear_dir;
	reg  signed [31:0]     gear_cmd_pos;
	reg                    in_position_flag;
	reg                    command_busy_flag;
	reg                    travel_complete_flag;
	reg                    rough_match_flag;
	reg  [`PGM_NFLAGS-1:0] flags_q;
	wire                   position_detected_flag;
	wire                   det_plus;
	wire                   det_minus;

	// ----------------------------------------
	// Ratio clamp
	// ----------------------------------------
	wire [24:0] num_x_lim = gear_numerator * `PGM_RATIO_LIMIT;
	wire [24:0] den_x_lim = gear_denominator * `PGM_RATIO_LIMIT;
	wire        ratio_low = (num_x_lim <= {10'h000, gear_denominator});
	wire        ratio_high = ({10'h000, gear_numerator} >= den_x_lim);
	reg  [14:0] eff_num;
	reg  [14:0] eff_den;

	// Out-of-range ratios collapse to the limit itself
	always @* begin
		if (ratio_low) begin
			eff_num = 15'h0001;
			eff_den = {5'h00, `PGM_RATIO_LIMIT};
		end else if (ratio_high) begin
			eff_num = {5'h00, `PGM_RATIO_LIMIT};
			eff_den = 15'h0001;
		end else begin
			eff_num = gear_numerator;
			eff_den = gear_denominator;
		end
	end

	// ----------------------------------------
	// Gear engine: one motor pulse per clock while remainder covers denominator
	// ----------------------------------------
	// Serial subtraction avoids a divider; a high ratio stalls the source via cmd_ready_o
	wire gear_step = (gear_rem >= {1'b0, eff_den});
	wire cmd_take = cmd_pulse_i && cmd_ready_o;

	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			gear_rem     <= 16'h0000;
			gear_dir     <= 1'b0;
			gear_cmd_pos <= 32'sh00000000;
			cmd_ready_o  <= 1'b0;
		end else begin
			if (gear_step) begin
				gear_rem <= gear_rem - {1'b0, eff_den};
				// Each step is one of 5120 motor pulses per revolution
				if (gear_dir) begin
					gear_cmd_pos <= gear_cmd_pos - 32'sh00000001;
				end else begin
					gear_cmd_pos <= gear_cmd_pos + 32'sh00000001;
				end
			end else if (cmd_take) begin
				gear_rem <= gear_rem + {1'b0, eff_num};
				gear_dir <= cmd_dir_i;
			end
			cmd_ready_o <= !gear_step && !cmd_take &&
				(gear_rem < {1'b0, eff_den});
		end
	end

	// ----------------------------------------
	// Distances
	// ----------------------------------------
	wire signed [32:0] droop = {gear_cmd_pos[31], gear_cmd_pos} -
		{fb_pos_i[31], fb_pos_i};
	wire signed [32:0] remain = {target_pos_i[31], target_pos_i} -
		{cur_pos_i[31], cur_pos_i};
	wire        [32:0] droop_mag = droop[32] ? (~droop + 33'h000000001) : droop;
	wire        [32:0] remain_mag = remain[32] ? (~remain + 33'h000000001) : remain;

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			in_position_flag     <= 1'b0;
			command_busy_flag    <= 1'b0;
			travel_complete_flag <= 1'b0;
			rough_match_flag     <= 1'b0;
		end else begin
			in_position_flag  <= (droop_mag < {18'h00000, in_position_width});
			// Busy also covers pulses still being geared out
			command_busy_flag <= cmd_creating_i || !cmd_ready_o;
			travel_complete_flag <= in_position_flag && !command_busy_flag;
			rough_match_flag  <= (remain_mag < {18'h00000, rough_match_range});
		end
	end

	// ----------------------------------------
	// Position detection
	// ----------------------------------------
	wire [26:0] det_value = detect_value_high_digits * `PGM_DIGITS_SCALE +
		{13'h0000, detect_value_low_digits};
	wire signed [32:0] det_level = {6'h00, det_value};
	wire signed [32:0] det_hyst = {18'h00000, detect_hysteresis_width};
	wire signed [32:0] cur_ext = {cur_pos_i[31], cur_pos_i};
	wire signed [32:0] cur_neg = ~cur_ext + 33'sh000000001;
	wire plus_en = (detect_side_select != `PGM_SIDE_MINUS);
	wire minus_en = (detect_side_select != `PGM_SIDE_PLUS);

	// Plus side: position above value
	pgm_hyst_detect u_det_plus (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.enable_i   (plus_en),
		.pos_i      (cur_ext),
		.level_i    (det_level),
		.hyst_i     (det_hyst),
		.flag_o     (det_plus)
	);

	// Minus side: negated position above value, same hysteresis
	pgm_hyst_detect u_det_minus (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.enable_i   (minus_en),
		.pos_i      (cur_neg),
		.level_i    (det_level),
		.hyst_i     (det_hyst),
		.flag_o     (det_minus)
	);

	assign position_detected_flag = det_plus || det_minus;

	wire [`PGM_NFLAGS-1:0] flags = {position_detected_flag, rough_match_flag,
		travel_complete_flag, command_busy_flag, in_position_flag};

	// ----------------------------------------
	// Terminal routing
	// ----------------------------------------
	// Unknown codes drive the terminal low
	function route;
		input [7:0]             code;
		input [`PGM_NFLAGS-1:0] f;
		reg   [7:0]             base;
		reg                     neg;
		reg                     val;
		begin
			neg  = (code >= `PGM_CODE_NEG);
			base = neg ? (code - `PGM_CODE_NEG) : code;
			case (base)
				`PGM_CODE_INPOS:  val = f[`PGM_F_INPOS];
				`PGM_CODE_BUSY:   val = f[`PGM_F_BUSY];
				`PGM_CODE_DONE:   val = f[`PGM_F_DONE];
				`PGM_CODE_ROUGH:  val = f[`PGM_F_ROUGH];
				`PGM_CODE_DETECT: val = f[`PGM_F_DETECT];
				default:          val = neg;
			endcase
			route = neg ? !val : val;
		end
	endfunction

	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			term_o <= 3'h0;
		end else begin
			term_o[0] <= route(term_sel[7:0], flags);
			term_o[1] <= route(term_sel[15:8], flags);
			term_o[2] <= route(term_sel[23:16], flags);
		end
	end

	// ----------------------------------------
	// Interrupts: rising flag edges set sticky status
	// ----------------------------------------
	wire                   setup = psel_i && !penable_i && !pready_o;
	wire                   wr = setup && pwrite_i;
	wire                   clr_hit = wr && (paddr_i == `PGM_IRQ_CLR_ADDR);
	wire [`PGM_NFLAGS-1:0] rise = flags & ~flags_q;

	// Set wins over a clear in the same cycle
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			flags_q  <= {`PGM_NFLAGS{1'b0}};
			irq_stat <= {`PGM_NFLAGS{1'b0}};
			irq_o    <= 1'b0;
		end else begin
			flags_q  <= flags;
			irq_stat <= (irq_stat & ~(clr_hit ? pwdata_i[`PGM_NFLAGS-1:0] :
				{`PGM_NFLAGS{1'b0}})) | rise;
			irq_o    <= |(irq_stat & irq_en);
		end
	end

	// ----------------------------------------
	// APB slave: answer in the first access cycle
	// ----------------------------------------
	// Out-of-range values are refused so parameters stay legal
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			gear_numerator           <= `PGM_GEAR_RST;
			gear_denominator         <= `PGM_GEAR_RST;
			in_position_width        <= `PGM_INPOS_RST;
			detect_hysteresis_width  <= `PGM_HYST_RST;
			rough_match_range        <= `PGM_ROUGH_RST;
			detect_value_low_digits  <= 14'h0000;
			detect_value_high_digits <= 14'h0000;
			detect_side_select       <= `PGM_SIDE_BOTH;
			term_sel                 <= `PGM_TERM_SEL_RST;
			irq_en                   <= {`PGM_NFLAGS{1'b0}};
			pready_o                 <= 1'b0;
			pslverr_o                <= 1'b0;
			prdata_o                 <= 32'h00000000;
		end else begin
			pready_o  <= setup;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
			if (setup) begin
				case (paddr_i)
				`PGM_GEAR_NUM_ADDR: begin
					prdata_o <= {17'h00000, gear_numerator};
					if (pwrite_i) begin
						if (pwdata_i[31:15] == 17'h00000 && pwdata_i[14:0] != 15'h0000)
							gear_numerator <= pwdata_i[14:0];
						else
							pslverr_o <= 1'b1;
					end
				end
				`PGM_GEAR_DEN_ADDR: begin
					prdata_o <= {17'h00000, gear_denominator};
					if (pwrite_i) begin
						if (pwdata_i[31:15] == 17'h00000 && pwdata_i[14:0] != 15'h0000)
							gear_denominator <= pwdata_i[14:0];
						else
							pslverr_o <= 1'b1;
					end
				end
				`PGM_INPOS_WID_ADDR: begin
					prdata_o <= {17'h00000, in_position_width};
					if (pwrite_i) begin
						if (pwdata_i[31:15] == 17'h00000)
							in_position_width <= pwdata_i[14:0];
						else
							pslverr_o <= 1'b1;
					end
				end
				`PGM_HYST_WID_ADDR: begin
					prdata_o <= {17'h00000, detect_hysteresis_width};
					if (pwrite_i) begin
						if (pwdata_i[31:15] == 17'h00000)
							detect_hysteresis_width <= pwdata_i[14:0];
						else
							pslverr_o <= 1'b1;
					end
				end
				`PGM_ROUGH_RNG_ADDR: begin
					prdata_o <= {17'h00000, rough_match_range};
					if (pwrite_i) begin
						if (pwdata_i[31:15] == 17'h00000)
							rough_match_range <= pwdata_i[14:0];
						else
							pslverr_o <= 1'b1;
					end
				end
				`PGM_DET_LOW_ADDR: begin
					prdata_o <= {18'h00000, detect_value_low_digits};
					if (pwrite_i) begin
						if (pwdata_i <= {18'h00000, `PGM_DIGITS_MAX})
							detect_value_low_digits <= pwdata_i[13:0];
						else
							pslverr_o <= 1'b1;
					end
				end
				`PGM_DET_HIGH_ADDR: begin
					prdata_o <= {18'h00000, detect_value_high_digits};
					if (pwrite_i) begin
						if (pwdata_i <= {18'h00000, `PGM_DIGITS_MAX})
							detect_value_high_digits <= pwdata_i[13:0];
						else
							pslverr_o <= 1'b1;
					end
				end
				`PGM_SIDE_SEL_ADDR: begin
					prdata_o <= {30'h00000000, detect_side_select};
					if (pwrite_i) begin
						if (pwdata_i <= {30'h00000000, `PGM_SIDE_MAX})
							detect_side_select <= pwdata_i[1:0];
						else
							pslverr_o <= 1'b1;
					end
				end
				`PGM_TERM_SEL_ADDR: begin
					prdata_o <= {8'h00, term_sel};
					if (pwrite_i)
						term_sel <= pwdata_i[23:0];
				end
				`PGM_FLAGS_ADDR: prdata_o <= {27'h0000000, flags};
				`PGM_IRQ_STAT_ADDR: prdata_o <= {27'h0000000, irq_stat};
				`PGM_IRQ_CLR_ADDR: prdata_o <= 32'h00000000;
				`PGM_IRQ_EN_ADDR: begin
					prdata_o <= {27'h0000000, irq_en};
					if (pwrite_i)
						irq_en <= pwdata_i[`PGM_NFLAGS-1:0];
				end
				default: pslverr_o <= 1'b1;
				endcase
			end
		end
	end

endmodule

// ---- design/pgm_regs.vh ----
// Register offsets, field layouts, reset values and terminal codes of the position helper
`ifndef PGM_REGS_VH
`define PGM_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PGM_GEAR_NUM_ADDR   8'h00
`define PGM_GEAR_DEN_ADDR   8'h04
`define PGM_INPOS_WID_ADDR  8'h08
`define PGM_HYST_WID_ADDR   8'h0c
`define PGM_ROUGH_RNG_ADDR  8'h10
`define PGM_DET_LOW_ADDR    8'h14
`define PGM_DET_HIGH_ADDR   8'h18
`define PGM_SIDE_SEL_ADDR   8'h1c
`define PGM_TERM_SEL_ADDR   8'h20
`define PGM_FLAGS_ADDR      8'h24
`define PGM_IRQ_STAT_ADDR   8'h28
`define PGM_IRQ_CLR_ADDR    8'h2c
`define PGM_IRQ_EN_ADDR     8'h30

// ----------------------------------------
// Ranges and reset values
// ----------------------------------------
`define PGM_PARAM_MAX       15'h7fff
`define PGM_GEAR_RST        15'h0001
`define PGM_INPOS_RST       15'h0064
`define PGM_HYST_RST        15'h0000
`define PGM_ROUGH_RST       15'h0000
`define PGM_DIGITS_MAX      14'h270f
`define PGM_DIGITS_SCALE    27'h0002710
`define PGM_SIDE_MAX        2'h2
`define PGM_SIDE_BOTH       2'h0
`define PGM_SIDE_PLUS       2'h1
`define PGM_SIDE_MINUS      2'h2
`define PGM_RATIO_LIMIT     10'h384
`define PGM_PULSES_PER_REV  13'h1400
`define PGM_TERM_SEL_RST    24'h000000

// ----------------------------------------
// Flag bit positions (flags, irq status, clear, enable)
// ----------------------------------------
`define PGM_F_INPOS   0
`define PGM_F_BUSY    1
`define PGM_F_DONE    2
`define PGM_F_ROUGH   3
`define PGM_F_DETECT  4
`define PGM_NFLAGS    5

// ----------------------------------------
// Terminal assignment codes; negative logic adds the offset
// ----------------------------------------
`define PGM_CODE_INPOS   8'h24
`define PGM_CODE_DONE    8'h26
`define PGM_CODE_ROUGH   8'h37
`define PGM_CODE_DETECT  8'h3c
`define PGM_CODE_BUSY    8'h3d
`define PGM_CODE_NEG     8'h64

`endif

// ---- dv/pgm_cmd_gen.sv ----
// Position command generator model feeding pulses into the gear
`timescale 1ns/1ps
module pgm_cmd_gen (
	input  wire        core_clk_i,
	input  wire        sys_rst_i,
	input  wire        start_i,
	input  wire [15:0] count_i,
	input  wire        dir_i,
	input  wire        stall_i,
	input  wire        cmd_ready_i,
	output reg         cmd_pulse_o,
	output reg         cmd_dir_o,
	output reg         creating_o
);
	reg [15:0] left;
	// Pulse held until taken; stall gives slow generation
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			left        <= 16'h0;
			cmd_pulse_o <= 1'b0;
			cmd_dir_o   <= 1'b0;
			creating_o  <= 1'b0;
		end else if (start_i) begin
			left       <= count_i;
			cmd_dir_o  <= dir_i;
			creating_o <= 1'b1;
		end else if (cmd_pulse_o) begin
			if (cmd_ready_i) begin
				cmd_pulse_o <= 1'b0;
				left        <= left - 16'h1;
			end
		end else if (left != 16'h0) begin
			if (!stall_i)
				cmd_pulse_o <= 1'b1;
		end else begin
			creating_o <= 1'b0;
		end
	end
endmodule

// ---- dv/pgm_position_gear_assertions.sv ----
// Port-level checker for the position gear and status flag block
`timescale 1ns/1ps
module pgm_position_gear_assertions (
	input wire        core_clk_i,
	input wire        sys_rst_i,
	input wire [7:0]  paddr_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire        pwrite_i,
	input wire [31:0] pwdata_i,
	input wire [31:0] prdata_o,
	input wire        pready_o,
	input wire        pslverr_o,
	input wire        cmd_pulse_i,
	input wire        cmd_dir_i,
	input wire        cmd_ready_o,
	input wire        cmd_creating_i,
	input wire [31:0] fb_pos_i,
	input wire [31:0] target_pos_i,
	input wire [31:0] cur_pos_i,
	input wire [2:0]  term_o,
	input wire        irq_o
);
	// ----------------------------------------
	// Steps of a bus access and of a pulse take
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_setup;
		psel_i && !penable_i && !pready_o;
	endsequence
	sequence s_take;
		cmd_pulse_i && cmd_ready_o;
	endsequence
	a_apb_answer: assert property (s_setup |=> pready_o) else $error("no answer");
	a_answer_single: assert property (pready_o |=> !pready_o) else $error("long answer");
	a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("stray error");
	a_unmapped_zero: assert property ((s_setup ##0 (!pwrite_i && paddr_i > 8'h30))
		|=> pslverr_o && prdata_o == 32'h0) else $error("unmapped read");
	a_num_refuse: assert property ((s_setup ##0 (pwrite_i && paddr_i == 8'h00
		&& (pwdata_i == 32'h0 || pwdata_i > 32'h7fff))) |=> pslverr_o) else $error("num");
	a_side_refuse: assert property ((s_setup ##0 (pwrite_i && paddr_i == 8'h1c
		&& pwdata_i > 32'h2)) |=> pslverr_o) else $error("side accepted");
	a_take_drops: assert property (s_take |=> !cmd_ready_o) else $error("ready held");
	// Clamped ratio bounds the steps of one pulse to 900
	a_steps_bounded: assert property ($fell(cmd_ready_o) |-> ##[1:1000] cmd_ready_o)
		else $error("gear stuck");
	a_idle_ready: assert property (cmd_ready_o && !cmd_pulse_i |=> cmd_ready_o)
		else $error("ready dropped");
	a_reset_quiet: assert property (@(posedge core_clk_i) disable iff (1'b0) sys_rst_i
		|=> !pready_o && !cmd_ready_o && term_o == 3'h0 && !irq_o) else $error("rst");
endmodule
bind pgm_position_gear pgm_position_gear_assertions u_pgm_asrt (.core_clk_i, .sys_rst_i,
	.paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
	.cmd_pulse_i, .cmd_dir_i, .cmd_ready_o, .cmd_creating_i, .fb_pos_i, .target_pos_i,
	.cur_pos_i, .term_o, .irq_o);

// ---- dv/tb.sv ----
// Self-checking bench for the position gear and status flag block
`timescale 1ns/1ps
module tb;
	reg        core_clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0;
	reg [7:0]  paddr = 0;
	reg [31:0] pwdata = 0, fb_pos = 0, target_pos = 0, cur_pos = 0, rd;
	reg        start = 0, dir = 0, stall = 0, err;
	reg [15:0] count = 0;
	wire [31:0] prdata;
	wire       pready, pslverr, cmd_pulse, cmd_dir, cmd_ready, creating, irq;
	wire [2:0] term;
	integer    n_errors = 0, checked = 0, seed = 32'h250b27ca, i, k, g, num, den, n, e;
	integer    dsd [0:9] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 2};
	integer    dcur [0:9] = '{10002, 10003, 9993, 9992, -10003, -9992, -10003, 10003,
		10003, -10003};
	integer    dexp [0:9] = '{0, 1, 1, 0, 1, 0, 0, 1, 0, 1};
	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	pgm_position_gear u_pgm_position_gear (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.cmd_pulse_i(cmd_pulse), .cmd_dir_i(cmd_dir), .cmd_ready_o(cmd_ready),
		.cmd_creating_i(creating), .fb_pos_i(fb_pos), .target_pos_i(target_pos),
		.cur_pos_i(cur_pos), .term_o(term), .irq_o(irq));
	pgm_cmd_gen u_pgm_cmd_gen (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.start_i(start), .count_i(count), .dir_i(dir), .stall_i(stall),
		.cmd_ready_i(cmd_ready), .cmd_pulse_o(cmd_pulse), .cmd_dir_o(cmd_dir),
		.creating_o(creating));
	// Random stalls make the generator slow at times
	always @(posedge core_clk_i) stall <= $random(seed) & 1;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task complete_run;
		begin
			$display("checked=%0d n_errors=%0d", checked, n_errors);
			if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Request held until the edge that sees pready
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge core_clk_i);
			psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
			@(posedge core_clk_i);
			penable <= 1;
			@(posedge core_clk_i);
			for (k = 0; pready !== 1'b1 && k < 50; k = k + 1) @(posedge core_clk_i);
			if (pready !== 1'b1) begin n_errors = n_errors + 1; complete_run; end
			rd = prdata; err = pslverr;
			psel <= 0; penable <= 0;
		end
	endtask
	task do_reset;
		begin
			sys_rst_i <= 1;
			repeat (12) @(posedge core_clk_i);
			sys_rst_i <= 0;
		end
	endtask
	// Geared steps of n pulses with the ratio clamped at 1/900 and 900
	function integer gpos(input integer n, input integer num, input integer den);
		if (num * 900 <= den) gpos = n / 900;
		else if (num >= 900 * den) gpos = n * 900;
		else gpos = n * num / den;
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		do_reset;
		for (i = 0; i < 10; i = i + 1) begin
			apb(0, (i == 9) ? 8'h30 : i * 4, 0);
			chk(rd, (i < 2) ? 1 : (i == 2) ? 100 : 0);
		end
		apb(0, 8'h40, 0);
		chk(err, 1);
		chk(rd, 0);
		apb(1, 8'h00, 0); chk(err, 1);
		apb(0, 8'h00, 0); chk(rd, 1);
		apb(1, 8'h1c, 3); chk(err, 1);
		apb(1, 8'h14, 10000); chk(err, 1);
		for (g = 0; g < 4; g = g + 1) begin
			num = (g == 0) ? 32767 : (g == 1) ? 1 : $unsigned($random(seed)) % 200 + 1;
			den = (g == 1) ? 32767 : (g == 0) ? 1 : $unsigned($random(seed)) % 200 + 1;
			n = (g == 1) ? 901 : (g == 0) ? 2 : $unsigned($random(seed)) % 20 + 1;
			e = gpos(n, num, den);
			do_reset;
			apb(1, 8'h00, num); apb(1, 8'h04, den);
			apb(1, 8'h20, 32'h0088263d);
			start <= 1; count <= n; dir <= $random(seed) & 1;
			@(posedge core_clk_i);
			start <= 0;
			repeat (4) @(posedge core_clk_i);
			chk(term[0], 1);
			for (k = 0; (creating || !cmd_ready) && k < 20000; k = k + 1) @(posedge core_clk_i);
			if (k >= 20000) begin n_errors = n_errors + 1; complete_run; end
			if (dir) e = -e;
			fb_pos <= e - 99;
			repeat (5) @(posedge core_clk_i);
			chk(term, 3'b010);
			fb_pos <= e - 100;
			repeat (5) @(posedge core_clk_i);
			chk(term, 3'b100);
		end
		e = $random(seed) % 1000000;
		apb(1, 8'h10, 5);
		for (i = 0; i < 3; i = i + 1) begin
			target_pos <= e; cur_pos <= e + ((i == 0) ? -4 : (i == 1) ? 4 : -5);
			repeat (2) @(posedge core_clk_i);
			apb(0, 8'h24, 0); chk(rd[3], (i < 2) ? 1 : 0);
		end
		cur_pos <= 0;
		apb(1, 8'h0c, 10); apb(1, 8'h14, 2); apb(1, 8'h18, 1);
		for (i = 0; i < 10; i = i + 1) begin
			apb(1, 8'h1c, dsd[i]);
			cur_pos <= dcur[i];
			repeat (2) @(posedge core_clk_i);
			apb(0, 8'h24, 0); chk(rd[4], dexp[i]);
		end
		// Route rough, detected and plain in-position codes; droop is 100 so in-position is off
		target_pos <= -10003;
		apb(1, 8'h20, 32'h00243c37);
		repeat (3) @(posedge core_clk_i);
		chk(term, 3'b011);
		chk(irq, 0);
		apb(1, 8'h30, 32'h10);
		repeat (2) @(posedge core_clk_i);
		chk(irq, 1);
		apb(1, 8'h2c, 32'h10);
		repeat (2) @(posedge core_clk_i);
		chk(irq, 0);
		apb(0, 8'h28, 0); chk(rd[4], 0);
		complete_run;
	end
endmodule
